// ### design/tone_cmd_pkg.sv
// tone command interpreter package: key codes, mute entry layout, macro sizes, timing
// assumes a decoded touch-tone key strobe at 50 MHz system clock
`default_nettype none
package tone_cmd_pkg;
  localparam int CLK_HZ        = 50000000;
  localparam int PROMPT_WAIT_MS = 5000;
  localparam int PROMPT_WAIT_CYC = PROMPT_WAIT_MS * (CLK_HZ / 1000);
  localparam int MUTE_ENTRIES  = 40;
  localparam int MACRO_COUNT   = 4;
  localparam int MACRO_DEPTH   = 32;
  localparam int BEEP_CYC      = 5000;
  // key codes
  localparam logic [3:0] KEY_STAR  = 4'hA;
  localparam logic [3:0] KEY_POUND = 4'hB;
  localparam logic [3:0] DIGIT_MAX = 4'h9;
  localparam logic [3:0] MUTE_LEAD  = 4'h4;
  localparam logic [3:0] MACRO_LEAD = 4'h5;
  localparam logic [3:0] TERM_DIGIT = 4'h8;
  // bus map
  localparam logic [7:0] REG_KEY_CTRL  = 8'h00;
  localparam logic [7:0] REG_MODE      = 8'h04;
  localparam logic [7:0] REG_STATUS    = 8'h08;
  localparam logic [7:0] REG_CHAN_IN   = 8'h0C;
  localparam logic [7:0] REG_MUTE_SEL  = 8'h10;
  localparam logic [7:0] REG_MUTE_DATA = 8'h14;
  localparam logic [7:0] REG_SUPP_LO   = 8'h18;
  localparam logic [7:0] REG_SUPP_HI   = 8'h1C;
  localparam logic [7:0] REG_MACRO_OUT = 8'h20;
  localparam int MODE_SETUP_BIT = 0;
  localparam int MODE_USER_BIT  = 1;
  localparam int KEY_VALID_BIT  = 4;

  typedef struct packed {
    logic       enabled;
    logic       active;
    logic [6:0] ctl_chan;
    logic       ctl_high;
    logic       tgt_meter;
    logic [6:0] tgt_chan;
  } mute_entry_t;
  localparam mute_entry_t MUTE_RESET = '{1'b0, 1'b0, 7'h01, 1'b0, 1'b1, 7'h01};

  typedef struct packed {
    logic       valid;
    logic [3:0] key;
  } key_evt_t;
endpackage
`default_nettype wire

// ### design/macro_store.sv
// macro_store: key memory for the stored sequences, one write and one read port
// assumes the interpreter serialises writes and reads
`default_nettype none
module macro_store
  import tone_cmd_pkg::*;
#(
  parameter int DEPTH = MACRO_DEPTH,
  parameter int COUNT = MACRO_COUNT
)(
  // clock and reset
  input  wire logic                           clk,
  input  wire logic                           rst_n,
  // write side
  input  wire logic                           wr_en,
  input  wire logic [$clog2(COUNT)-1:0]       wr_sel,
  input  wire logic [$clog2(DEPTH)-1:0]       wr_addr,
  input  wire logic [3:0]                     wr_key,
  input  wire logic                           len_we,
  input  wire logic [$clog2(DEPTH+1)-1:0]     len_val,
  // read side
  input  wire logic [$clog2(COUNT)-1:0]       rd_sel,
  input  wire logic [$clog2(DEPTH)-1:0]       rd_addr,
  output logic      [3:0]                     rd_key,
  output logic      [$clog2(DEPTH+1)-1:0]     rd_len
);
  logic [3:0]                 mem [COUNT*DEPTH];
  logic [$clog2(DEPTH+1)-1:0] len_q [COUNT];

  // the packed {sel, addr} index only covers the memory when both sizes are powers of two
  if (COUNT < 2 || DEPTH < 4 || (1 << $clog2(COUNT)) != COUNT || (1 << $clog2(DEPTH)) != DEPTH)
  begin : g_bad_size
    $error("macro_store: sizes must be powers of two, at least 2 and 4");
  end

  always_ff @(posedge clk)
  begin
    if (wr_en)
      mem[{wr_sel, wr_addr}] <= wr_key;
  end

  // empty after reset: a zero length means a disabled sequence
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      for (int i = 0; i < COUNT; i++) len_q[i] <= '0;
    else if (len_we)
      len_q[wr_sel] <= len_val;
  end

  assign rd_key = mem[{rd_sel, rd_addr}];
  assign rd_len = len_q[rd_sel];
endmodule
`default_nettype wire

// ### design/tone_cmd.sv
// tone_cmd: touch-tone mute programming and macro sequence interpreter, AHB-Lite slave
// assumes decoded keys arrive over the bus; channel states written by software
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`default_nettype none
// Function
// - forty mute entries addressed 401 to 440
// - pound after mute code enables and programs; star disables
// - no entry before timeout: single beep, keep value, next prompt
// - a keyed value is stored and acknowledged with two beeps
// - condition: star low, pound high
// - target type: pound metering, star status
// - active entry suppresses its target channel alarms and commands; the code suppresses only target channels 00 to 31
// - four macros of up to 32 keys
// - macros start empty; empty reads as disabled
// - macros addressed 501 to 504
// - record ends on 888 or at 32 keys
// - access code then 888 erases the macro
// - recording only in set-up mode
// - 000 in a macro reads out pending alarms
// - another macro code inside a macro chains into it
// - any key during execution aborts the macro
// - execution only in user or operator mode
// - 060 clock, 7xx* status and 6xx* meter read codes pass through
// - active entry releases when controlling channel returns
module tone_cmd
  import tone_cmd_pkg::*;
#(
  parameter int PROMPT_WAIT = PROMPT_WAIT_CYC,
  parameter int BEEP_LEN    = BEEP_CYC
)(
  // clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RESET_N,
  // ahb-lite slave
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  // operator feedback
  output logic             BEEP,
  // executed key stream and alarm readout request
  output logic             MACRO_KEY_VALID,
  output logic      [3:0]  MACRO_KEY,
  output logic             ALARM_READOUT
);
  typedef enum {S_IDLE, S_D2, S_D3, S_MUTE_OP, S_P_CTL, S_P_COND, S_P_TYPE, S_P_TGT,
                S_REC, S_RUN, S_RUN_GAP} state_t;

  function automatic logic is_digit(input logic [3:0] k);
    return k <= DIGIT_MAX;
  endfunction

  if (PROMPT_WAIT < 1 || BEEP_LEN < 1)
  begin : g_bad_timing
    $error("tone_cmd: bad timing parameter");
  end

  // bus registers
  logic        ap_valid_q, ap_valid_d, ap_write_q, ap_write_d;
  logic [7:0]  ap_addr_q, ap_addr_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [1:0]  mode_q, mode_d;
  logic [63:0] chan_in_q, chan_in_d;
  logic [5:0]  mute_sel_q, mute_sel_d;
  key_evt_t    key_in;
  // interpreter
  state_t      st_q, st_d;
  logic [3:0]  k1_q, k1_d, k2_q, k2_d;
  logic        have1_q, have1_d;
  logic [5:0]  ent_q, ent_d;
  logic [1:0]  mac_q, mac_d;
  logic [5:0]  pos_q, pos_d;
  logic [1:0]  run_q, run_d;
  logic [5:0]  tail_q, tail_d;
  logic [31:0] wait_q, wait_d;
  logic [1:0]  beeps_q, beeps_d;
  logic [31:0] beep_cnt_q, beep_cnt_d;
  logic        beep_q, beep_d;
  logic        mkv_q, mkv_d, alarm_q, alarm_d;
  logic [3:0]  mk_q, mk_d;
  mute_entry_t mute_q [MUTE_ENTRIES];
  mute_entry_t mute_d [MUTE_ENTRIES];
  logic [63:0] supp_q, supp_d;
  // macro store port
  logic        m_wr, m_lwe;
  logic [4:0]  m_waddr, m_raddr;
  logic [5:0]  m_lval, m_len;
  logic [3:0]  m_wkey, m_rkey;
  logic [1:0]  m_wsel, m_rsel;

  macro_store #(.DEPTH(MACRO_DEPTH), .COUNT(MACRO_COUNT)) u_store (
    .clk(SYS_CLK), .rst_n(RESET_N),
    .wr_en(m_wr), .wr_sel(m_wsel), .wr_addr(m_waddr), .wr_key(m_wkey),
    .len_we(m_lwe), .len_val(m_lval),
    .rd_sel(m_rsel), .rd_addr(m_raddr), .rd_key(m_rkey), .rd_len(m_len)
  );

  // ahb-lite: zero wait states, always okay, unmapped reads give zero
  always_comb
  begin
    ap_valid_d = HSEL && HREADY && HTRANS[1];
    ap_write_d = HWRITE;
    ap_addr_d  = HADDR[7:0];
    mode_d     = mode_q;
    chan_in_d  = chan_in_q;
    mute_sel_d = mute_sel_q;
    key_in     = '{1'b0, 4'h0};
    hrdata_d   = 32'h0000_0000;
    if (ap_valid_q && ap_write_q)
    begin
      case (ap_addr_q)
        REG_KEY_CTRL:  key_in = '{HWDATA[KEY_VALID_BIT], HWDATA[3:0]};
        REG_MODE:      mode_d = HWDATA[1:0];
        REG_CHAN_IN:   chan_in_d[31:0] = HWDATA;
        // only the low channel word is writable: the next word is the entry select
        REG_MUTE_SEL:  mute_sel_d = HWDATA[5:0];
        default: ;
      endcase
    end
    if (ap_valid_d && !HWRITE)
    begin
      case (HADDR[7:0])
        REG_MODE:      hrdata_d = {30'h0, mode_q};
        REG_STATUS:    hrdata_d = {20'h0, 4'(st_q), 2'(run_q), 2'(mac_q), 4'(beeps_q)};
        REG_MUTE_DATA: hrdata_d = {14'h0, mute_q[mute_sel_q < 6'(MUTE_ENTRIES) ? mute_sel_q : 6'h00]};
        REG_SUPP_LO:   hrdata_d = supp_q[31:0];
        REG_SUPP_HI:   hrdata_d = supp_q[63:32];
        REG_MACRO_OUT: hrdata_d = {26'h0, m_len};
        default:       hrdata_d = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q  <= 8'h00;
      hrdata_q   <= 32'h0000_0000;
      mode_q     <= 2'h0;
      chan_in_q  <= 64'h0;
      mute_sel_q <= 6'h00;
    end
    else
    begin
      ap_valid_q <= ap_valid_d;
      ap_write_q <= ap_write_d;
      ap_addr_q  <= ap_addr_d;
      hrdata_q   <= hrdata_d;
      mode_q     <= mode_d;
      chan_in_q  <= chan_in_d;
      mute_sel_q <= mute_sel_d;
    end
  end

  // interpreter next state
  always_comb
  begin
    logic [3:0] k;
    logic [6:0] two;
    logic [6:0] code;
    k = key_in.key;
    two = 7'(k1_q) * 7'h0A + 7'(k);
    code = 7'(k2_q) * 7'h0A + 7'(k);
    st_d = st_q; k1_d = k1_q; k2_d = k2_q; have1_d = have1_q;
    ent_d = ent_q; mac_d = mac_q; pos_d = pos_q; run_d = run_q; tail_d = tail_q;
    wait_d = wait_q; beeps_d = beeps_q; mkv_d = 1'b0; mk_d = mk_q; alarm_d = 1'b0;
    mute_d = mute_q;
    m_wr = 1'b0; m_lwe = 1'b0; m_wsel = mac_q; m_waddr = pos_q[4:0]; m_wkey = k;
    // outside replay the length port shows the macro last addressed
    m_lval = pos_q; m_rsel = (st_q == S_RUN) ? run_q : mac_q; m_raddr = pos_q[4:0];
    // a prompt whose wait runs out keeps its value and moves on
    if (wait_q != 32'h0 && !key_in.valid)
    begin
      wait_d = wait_q - 32'h1;
      if (wait_q == 32'h1)
      begin
        beeps_d = 2'h1;
        have1_d = 1'b0;
        case (st_q)
          S_P_CTL:  begin st_d = S_P_COND; wait_d = 32'(PROMPT_WAIT); end
          S_P_COND: begin st_d = S_P_TYPE; wait_d = 32'(PROMPT_WAIT); end
          S_P_TYPE: begin st_d = S_P_TGT;  wait_d = 32'(PROMPT_WAIT); end
          default:  st_d = S_IDLE;
        endcase
      end
    end
    case (st_q)
      S_IDLE: if (key_in.valid && is_digit(k)) begin k1_d = k; st_d = S_D2; end
      S_D2:   if (key_in.valid) begin k2_d = k; st_d = is_digit(k) ? S_D3 : S_IDLE; end
      S_D3:
        if (key_in.valid)
        begin
          st_d = S_IDLE;
          if (k1_q == MUTE_LEAD && is_digit(k2_q) && is_digit(k) && code >= 7'h01
              && code <= 7'(MUTE_ENTRIES))
          begin
            ent_d = 6'(code - 7'h01);
            st_d  = S_MUTE_OP;
          end
          else if (k1_q == MACRO_LEAD && k2_q == 4'h0 && k >= 4'h1 && k <= 4'(MACRO_COUNT))
          begin
            mac_d = 2'(k - 4'h1);
            pos_d = 6'h00;
            tail_d = 6'h00;
            if (mode_q[MODE_SETUP_BIT])
              st_d = S_REC;
            else if (mode_q[MODE_USER_BIT])
            begin
              run_d = 2'(k - 4'h1);
              st_d  = S_RUN;
            end
          end
        end
      S_MUTE_OP:
        if (key_in.valid)
        begin
          st_d = S_IDLE;
          if (k == KEY_POUND)
          begin
            mute_d[ent_q].enabled = 1'b1;
            st_d = S_P_CTL;
            wait_d = 32'(PROMPT_WAIT);
          end
          else if (k == KEY_STAR)
          begin
            mute_d[ent_q].enabled = 1'b0;
            mute_d[ent_q].active  = 1'b0;
          end
        end
      S_P_CTL, S_P_TGT:
        if (key_in.valid && is_digit(k))
        begin
          if (!have1_q)
          begin
            k1_d = k; have1_d = 1'b1; wait_d = 32'(PROMPT_WAIT);
          end
          else
          begin
            have1_d = 1'b0;
            beeps_d = 2'h2;
            if (st_q == S_P_CTL)
            begin
              mute_d[ent_q].ctl_chan = two;
              st_d = S_P_COND; wait_d = 32'(PROMPT_WAIT);
            end
            else
            begin
              mute_d[ent_q].tgt_chan = two;
              st_d = S_IDLE; wait_d = 32'h0;
            end
          end
        end
      S_P_COND, S_P_TYPE:
        if (key_in.valid && (k == KEY_STAR || k == KEY_POUND))
        begin
          beeps_d = 2'h2;
          wait_d = 32'(PROMPT_WAIT);
          if (st_q == S_P_COND)
          begin
            mute_d[ent_q].ctl_high = (k == KEY_POUND);
            st_d = S_P_TYPE;
          end
          else
          begin
            mute_d[ent_q].tgt_meter = (k == KEY_POUND);
            st_d = S_P_TGT;
          end
        end
      S_REC:
        if (key_in.valid)
        begin
          tail_d = (k == TERM_DIGIT) ? tail_q + 6'h01 : 6'h00;
          if (k == TERM_DIGIT && tail_q == 6'h02)
          begin
            m_lwe = 1'b1;
            m_lval = pos_q - 6'h02;
            st_d = S_IDLE;
          end
          else
          begin
            m_wr = 1'b1;
            pos_d = pos_q + 6'h01;
            if (pos_q == 6'(MACRO_DEPTH - 1))
            begin
              m_lwe = 1'b1;
              m_lval = 6'(MACRO_DEPTH);
              st_d = S_IDLE;
            end
          end
        end
      S_RUN:
        if (key_in.valid)
          st_d = S_IDLE;
        else if (pos_q >= m_len)
          st_d = S_IDLE;
        else
        begin
          // replay key; codes such as 060, 7xx*, 6xx* go out unchanged for the reader logic
          mkv_d = 1'b1;
          mk_d  = m_rkey;
          tail_d = 6'h00;
          k2_d = k1_q; k1_d = m_rkey;
          if (m_rkey == 4'h0 && k1_q == 4'h0 && k2_q == 4'h0 && pos_q >= 6'h02)
            alarm_d = 1'b1;
          pos_d = pos_q + 6'h01;
          st_d = S_RUN_GAP;
          if (k2_q == MACRO_LEAD && k1_q == 4'h0 && m_rkey >= 4'h1 && m_rkey <= 4'(MACRO_COUNT)
              && pos_q >= 6'h02)
          begin
            run_d = 2'(m_rkey - 4'h1);
            pos_d = 6'h00;
          end
        end
      S_RUN_GAP: st_d = key_in.valid ? S_IDLE : S_RUN;
      default: st_d = S_IDLE;
    endcase
    if (st_q == S_RUN && st_d == S_RUN_GAP && pos_q == 6'h00)
    begin
      k1_d = m_rkey; k2_d = 4'hF;
    end
    // entries arm on the controlling condition and drop when it returns
    for (int i = 0; i < MUTE_ENTRIES; i++)
      mute_d[i].active = mute_d[i].enabled && (chan_in_q[mute_q[i].ctl_chan[5:0]] == mute_q[i].ctl_high);
    // built from the next entry state so suppression never trails the entry by a cycle
    supp_d = 64'h0;
    for (int i = 0; i < MUTE_ENTRIES; i++)
      if (mute_d[i].active && mute_d[i].tgt_meter && mute_d[i].tgt_chan < 7'h20)
        supp_d[32 + mute_d[i].tgt_chan[4:0]] = 1'b1;
      else if (mute_d[i].active && !mute_d[i].tgt_meter && mute_d[i].tgt_chan < 7'h20)
        supp_d[mute_d[i].tgt_chan[4:0]] = 1'b1;
  end

  // beep generator: plays pending beeps one after another with a gap
  always_comb
  begin
    beep_cnt_d = beep_cnt_q;
    beep_d = beep_q;
    if (beep_cnt_q != 32'h0)
      beep_cnt_d = beep_cnt_q - 32'h1;
    else if (beep_q)
    begin
      beep_d = 1'b0;
      beep_cnt_d = 32'(BEEP_LEN);
    end
    else if (beeps_q != 2'h0 && beeps_d == beeps_q)
    begin
      beep_d = 1'b1;
      beep_cnt_d = 32'(BEEP_LEN);
    end
  end

  always_ff @(posedge SYS_CLK or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      st_q <= S_IDLE; k1_q <= 4'h0; k2_q <= 4'h0; have1_q <= 1'b0;
      ent_q <= 6'h00; mac_q <= 2'h0; pos_q <= 6'h00; run_q <= 2'h0; tail_q <= 6'h00;
      wait_q <= 32'h0; beeps_q <= 2'h0; beep_cnt_q <= 32'h0; beep_q <= 1'b0;
      mkv_q <= 1'b0; mk_q <= 4'h0; alarm_q <= 1'b0; supp_q <= 64'h0;
      for (int i = 0; i < MUTE_ENTRIES; i++) mute_q[i] <= MUTE_RESET;
    end
    else
    begin
      st_q <= st_d; k1_q <= k1_d; k2_q <= k2_d; have1_q <= have1_d;
      ent_q <= ent_d; mac_q <= mac_d; pos_q <= pos_d; run_q <= run_d; tail_q <= tail_d;
      wait_q <= wait_d;
      beeps_q <= (beep_q && !beep_d && beeps_d == beeps_q) ? beeps_q - 2'h1 : beeps_d;
      beep_cnt_q <= beep_cnt_d; beep_q <= beep_d;
      mkv_q <= mkv_d; mk_q <= mk_d; alarm_q <= alarm_d; supp_q <= supp_d;
      for (int i = 0; i < MUTE_ENTRIES; i++) mute_q[i] <= mute_d[i];
    end
  end

  assign HRDATA = hrdata_q;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign BEEP = beep_q;
  assign MACRO_KEY_VALID = mkv_q;
  assign MACRO_KEY = mk_q;
  assign ALARM_READOUT = alarm_q;

  chk_star_disables: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (st_q == S_MUTE_OP && key_in.valid && key_in.key == KEY_STAR) |=> !mute_q[ent_q].enabled)
    else $error("star did not disable entry");
  chk_pound_prompts: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (st_q == S_MUTE_OP && key_in.valid && key_in.key == KEY_POUND) |=> st_q == S_P_CTL)
    else $error("pound did not open prompts");
  chk_abort_run: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    ((st_q == S_RUN || st_q == S_RUN_GAP) && key_in.valid) |=> st_q == S_IDLE)
    else $error("key did not abort macro");
  chk_rec_setup: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (st_q != S_REC && st_d == S_REC) |-> mode_q[MODE_SETUP_BIT])
    else $error("recording outside set-up");
  chk_run_user: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (st_q == S_D3 && st_d == S_RUN) |-> mode_q[MODE_USER_BIT])
    else $error("macro ran outside user mode");
  chk_ack_two: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (st_q == S_P_COND && key_in.valid && key_in.key == KEY_STAR) |=> beeps_q == 2'h2)
    else $error("no double beep");
  chk_timeout_one: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (wait_q == 32'h1 && !key_in.valid && st_q == S_P_CTL) |=> (st_q == S_P_COND && beeps_q == 2'h1))
    else $error("timeout did not single beep");
  chk_cond_code: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    (st_q == S_P_COND && key_in.valid && key_in.key == KEY_POUND) |=> mute_q[ent_q].ctl_high)
    else $error("pound not stored as high");
  chk_rec_limit: assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
    st_q == S_REC |-> pos_q <= 6'(MACRO_DEPTH))
    else $error("record past depth");
endmodule
`default_nettype wire

// ### verification/operator_model.sv
// operator_model: remote keypad operator, sending decoded keys as ahb-lite single word writes
// assumes one slave whose hreadyout is fed back as hready; waits on hready with no fixed latency
`default_nettype none
module operator_model
  import tone_cmd_pkg::*;
(
  // bus clock and answer
  input  wire logic        clk,
  input  wire logic        hready,
  input  wire logic [31:0] hrdata,
  // bus request
  output logic             hsel,
  output logic [31:0]      haddr,
  output logic [1:0]       htrans,
  output logic             hwrite,
  output logic [2:0]       hsize,
  output logic [31:0]      hwdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // an idle edge before each request keeps back to back calls from driving htrans twice in one step
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    r = hrdata;
  endtask

  task automatic press(input logic [3:0] k);
    logic [31:0] r;
    xfer(REG_KEY_CTRL, 1'b1, {27'h0, 1'b1, k}, r);
  endtask

  // channel numbers always go as two decimal digits
  task automatic two(input int n);
    press(4'(n / 10));
    press(4'(n % 10));
  endtask
endmodule
`default_nettype wire

// ### verification/testbench.sv
// testbench: mute programming and macro record, replay, chain and abort of tone_cmd
// assumes short prompt wait and beep length parameters so timeouts fit a short run
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import tone_cmd_pkg::*;
  localparam int WAIT = 50;
  localparam int BLEN = 4;
  // the operator waits out the double beep before keying the next value
  localparam int HUSH = 6 * BLEN;

  logic             sys_clk, reset_n, hsel, hwrite, hreadyout, hresp, beep, mkv, alarm, beep_q;
  logic [31:0]      haddr, hwdata, hrdata, r;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic [3:0]       mkey;
  logic [3:0]       keys[$];
  logic [3:0]       mq[4][$];
  int               fails, tests_run, beeps, alarms, a0, b0, ia, ta, tb;

  tone_cmd #(.PROMPT_WAIT(WAIT), .BEEP_LEN(BLEN)) tone_cmd_i (
    .SYS_CLK(sys_clk), .RESET_N(reset_n), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata),
    .HREADYOUT(hreadyout), .HRESP(hresp), .BEEP(beep), .MACRO_KEY_VALID(mkv),
    .MACRO_KEY(mkey), .ALARM_READOUT(alarm));

  operator_model operator_model_i (
    .clk(sys_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk)
  begin
    beep_q <= beep;
    if (beep === 1'b1 && beep_q !== 1'b1) beeps++;
    if (mkv === 1'b1) keys.push_back(mkey);
    if (alarm === 1'b1) alarms++;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      fails++;
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    operator_model_i.xfer(a, 1'b1, d, r);
  endtask

  task automatic rd(input logic [7:0] a);
    operator_model_i.xfer(a, 1'b0, 32'h0, r);
  endtask

  task automatic key(input logic [3:0] k);
    operator_model_i.press(k);
  endtask

  function automatic logic [31:0] mute_w(logic en, act, int ctl, logic hi, met, int tgt);
    mute_entry_t m;
    m = '{en, act, 7'(ctl), hi, met, 7'(tgt)};
    return {14'h0, m};
  endfunction

  task automatic prog(input int idx, input int ctl, input logic hi, input logic met, input int tgt);
    key(MUTE_LEAD);
    operator_model_i.two(idx);
    key(KEY_POUND);
    operator_model_i.two(ctl);
    repeat (HUSH) @(posedge sys_clk);
    key(hi ? KEY_POUND : KEY_STAR);
    repeat (HUSH) @(posedge sys_clk);
    key(met ? KEY_POUND : KEY_STAR);
    repeat (HUSH) @(posedge sys_clk);
    operator_model_i.two(tgt);
    repeat (HUSH) @(posedge sys_clk);
  endtask

  task automatic rec(input int n, input logic term);
    key(MACRO_LEAD);
    key(4'h0);
    key(4'(n));
    for (int i = 0; i < mq[n-1].size(); i++) key(mq[n-1][i]);
    if (term) repeat (3) key(TERM_DIGIT);
    rd(REG_MACRO_OUT);
    chk("macro length", mq[n-1].size(), r);
  endtask

  task automatic play(input int n, input int w);
    keys.delete();
    a0 = alarms;
    key(MACRO_LEAD);
    key(4'h0);
    key(4'(n));
    repeat (w) @(posedge sys_clk);
  endtask

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    report_and_stop();
  end

  initial
  begin
    reset_n = 1'b0;
    void'($urandom(32'h034A413E));
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    chk("beep idle", 0, beep);
    rd(REG_MACRO_OUT);
    chk("empty macro", 0, r);
    chk("okay response", 0, hresp);
    $display("reset test done");
    ia = 3 + $urandom_range(36);
    ta = $urandom_range(31);
    tb = $urandom_range(31);
    wr(REG_CHAN_IN, 32'h8);
    b0 = beeps;
    prog(ia, 2, 1'b0, 1'b1, ta);
    prog(40, 3, 1'b1, 1'b0, tb);
    repeat (200) @(posedge sys_clk);
    chk("ack beeps", b0 + 16, beeps);
    wr(REG_MUTE_SEL, ia - 1);
    rd(REG_MUTE_DATA);
    chk("entry a", mute_w(1, 1, 2, 0, 1, ta), r);
    wr(REG_MUTE_SEL, 39);
    rd(REG_MUTE_DATA);
    chk("entry 40", mute_w(1, 1, 3, 1, 0, tb), r);
    rd(REG_SUPP_HI);
    chk("meter muted", 32'h1 << ta, r);
    rd(REG_SUPP_LO);
    chk("status muted", 32'h1 << tb, r);
    wr(REG_CHAN_IN, 32'h6);
    rd(REG_SUPP_HI);
    chk("meter released", 0, r);
    rd(REG_SUPP_LO);
    chk("status released", 0, r);
    b0 = beeps;
    key(MUTE_LEAD);
    operator_model_i.two(2);
    key(KEY_POUND);
    repeat (8 * WAIT) @(posedge sys_clk);
    chk("timeout beeps", b0 + 4, beeps);
    wr(REG_MUTE_SEL, 1);
    wr(REG_CHAN_IN, 32'h4);
    rd(REG_MUTE_DATA);
    chk("kept values", mute_w(1, 1, 1, 0, 1, 1), r);
    rd(REG_SUPP_HI);
    chk("default muted", 32'h2, r);
    key(MUTE_LEAD);
    operator_model_i.two(2);
    key(KEY_STAR);
    rd(REG_MUTE_DATA);
    chk("disabled", 0, r & 32'h20000);
    rd(REG_SUPP_HI);
    chk("disabled no mute", 0, r);
    $display("mute test done");
    repeat (1 + $urandom_range(11)) mq[0].push_back(4'h1 + 4'($urandom_range(2)));
    mq[1] = {4'h1, 4'h0, 4'h0, 4'h0};
    mq[2] = {4'h6, 4'h5, 4'h0, 4'h2};
    repeat (32) mq[3].push_back(4'h1 + 4'($urandom_range(2)));
    wr(REG_MODE, 32'h1);
    for (int m = 1; m <= 4; m++) rec(m, m < 4);
    wr(REG_MODE, 32'h0);
    play(1, 40);
    chk("no replay", 0, keys.size());
    wr(REG_MODE, 32'h2);
    for (int m = 1; m <= 2; m++)
    begin
      play(m, 80);
      chk("replay count", mq[m-1].size(), keys.size());
      for (int i = 0; i < mq[m-1].size(); i++) chk("replay key", mq[m-1][i], keys[i]);
    end
    chk("alarm readout", a0 + 1, alarms);
    play(3, 80);
    chk("chain alarm", a0 + 1, alarms);
    chk("chain first", 4'h6, keys[0]);
    wr(REG_MODE, 32'h1);
    key(MACRO_LEAD);
    key(4'h0);
    key(4'h1);
    repeat (3) key(TERM_DIGIT);
    rd(REG_MACRO_OUT);
    chk("erased", 0, r);
    wr(REG_MODE, 32'h2);
    play(4, 6);
    key(4'h9);
    repeat (100) @(posedge sys_clk);
    chk("aborted", 1, keys.size() < 32);
    $display("macro test done");
    report_and_stop();
  end
endmodule
`default_nettype wire
